// file: mpwm_host.sv
// host model: frames, diagnosis readout, external pwm clock
`timescale 1ns/1ps
module mpwm_host #(
  parameter int HALF_CYC = 80
) (
  input wire logic i_clock,
  input wire logic [15:0] i_rsp_word,
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_word,
  output logic o_diag_read,
  output logic o_pwm_clk_pin
);
  // ======
  // external clock, parks low when stopped
  logic clk_run = 1'b1;
  int hcnt = 0;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_word = 16'h0000;
    o_diag_read = 1'b0;
    o_pwm_clk_pin = 1'b0;
  end
  always @(negedge i_clock) begin
    hcnt <= (!clk_run || hcnt == HALF_CYC - 1) ? 0 : hcnt + 1;
    if (!clk_run) o_pwm_clk_pin <= 1'b0;
    else if (hcnt == HALF_CYC - 1) o_pwm_clk_pin <= ~o_pwm_clk_pin;
  end
  // ======
  // two frames back to back, answer of the second
  task automatic acc(input logic [15:0] w1, input logic [15:0] w2, output logic [15:0] r);
    @(negedge i_clock);
    o_cmd_valid = 1'b1;
    o_cmd_word = w1;
    @(negedge i_clock);
    o_cmd_word = w2;
    // answer of the second frame stays on i_rsp_word while o_cmd_word keeps the second frame
    @(negedge i_clock);
    r = i_rsp_word;
    o_cmd_valid = 1'b0;
  endtask : acc
  task automatic diag_rd();
    @(negedge i_clock);
    o_diag_read = 1'b1;
    @(negedge i_clock);
    o_diag_read = 1'b0;
  endtask : diag_rd
endmodule : mpwm_host

// file: mpwm_pkg.sv
// shared constants and types of the multichannel pwm generator
package mpwm_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_CH = 6;
  localparam int DATA_W = 10;
  localparam int CNT_W = 10;
  localparam int DUTY_W = 9;
  // ==========================================================
  // command frame layout
  localparam int FR_WRITE_BIT = 15;
  localparam int FR_BANK_BIT = 14;
  localparam int FR_ADDR_HI = 13;
  localparam int FR_ADDR_LO = 10;
  localparam int FR_CH_HI = 12;
  localparam int FR_CH_LO = 10;
  localparam int FR_CH_SEL_BIT = 13;
  localparam logic [3:0] ADDR_HW_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_PWM_CONFIG = 4'h7;
  // ==========================================================
  // field positions
  localparam int HW_TRIM_HI = 8;
  localparam int HW_TRIM_LO = 6;
  localparam int HW_CLK_BIT = 5;
  localparam int HW_LOAD_TYPE_SEL_3_BIT = 3;
  localparam int HW_LOAD_TYPE_SEL_2_BIT = 2;
  localparam int HW_STBY_BIT = 1;
  localparam int PC_EN_BIT = 0;
  localparam int PC_DPH_HI = 2;
  localparam int PC_DPH_LO = 1;
  localparam int PC_DCS_BIT = 3;
  localparam int CH_PRESC_HI = 1;
  localparam int CH_PRESC_LO = 0;
  localparam int CH_SYDEL_HI = 3;
  localparam int CH_SYDEL_LO = 2;
  localparam int CH_PHASE_HI = 6;
  localparam int CH_PHASE_LO = 4;
  localparam int DIAG_LOSS_BIT = 11;
  // ==========================================================
  // codes and units
  localparam logic [1:0] PRESC_NORMAL = 2'h0;
  localparam logic [1:0] PRESC_DIV1 = 2'h1;
  localparam logic [1:0] PRESC_DIV2 = 2'h2;
  localparam logic [2:0] TRIM_NEUTRAL = 3'h4;
  localparam int PHASE_SHIFT = 5;
  localparam int SYNC_SHIFT = 3;
  localparam int DEV_SHIFT = 3;
  localparam logic [CNT_W-1:0] MASK_DIV1 = 10'h0ff;
  localparam logic [CNT_W-1:0] MASK_DIV2 = 10'h1ff;
  localparam logic [CNT_W-1:0] MASK_DIV4 = 10'h3ff;
  // ==========================================================
  // timing
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int INT_OSC_HZ = 105_000;
  localparam int TRIM_STEP_PCT = 5;
  localparam int LOSS_TH_HZ = 34_000;
  localparam int INT_DIV_CYC = SYS_CLK_HZ / INT_OSC_HZ;
  localparam int TRIM_STEP_CYC = INT_DIV_CYC * TRIM_STEP_PCT / 100;
  localparam int LOSS_CYC = (SYS_CLK_HZ + LOSS_TH_HZ - 1) / LOSS_TH_HZ;
  // ==========================================================
  // types
  typedef struct packed {
    logic [2:0] trim;
    logic clk_int;
    logic load_type_sel_3;
    logic load_type_sel_2;
  } mpwm_hw_t;
  typedef struct packed {
    logic duty_source_select;
    logic [1:0] dev_phase;
    logic en;
  } mpwm_pcfg_t;
  typedef struct packed {
    logic [2:0] phase;
    logic [1:0] sydel;
    logic [1:0] presc;
  } mpwm_chcfg_t;
  typedef struct packed {
    logic [DUTY_W-1:0] duty;
    mpwm_chcfg_t cfg;
  } mpwm_shadow_t;
  localparam mpwm_hw_t HW_RESET = '{trim: TRIM_NEUTRAL, clk_int: 1'b0, load_type_sel_3: 1'b0, load_type_sel_2: 1'b0};
endpackage : mpwm_pkg

// file: mpwm_sva.sv
// port checker of the pwm generator
`timescale 1ns/1ps
module mpwm_sva
  import mpwm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_word,
  input wire logic i_diag_read,
  input wire logic [NUM_CH-1:0] i_channel_switch,
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_word,
  input wire logic [15:0] o_diag_word,
  input wire logic [NUM_CH-1:0] o_channel_on,
  input wire logic [NUM_CH-1:0] o_sense_sync
);
  // ======
  // frame sequences
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_fr(logic w, logic b, logic [3:0] a);
    i_cmd_valid && i_cmd_word[15:10] == {w, b, a};
  endsequence
  sequence s_wr_rd(logic b, logic [3:0] a);
    s_fr(1'b1, b, a) ##1 s_fr(1'b0, b, a);
  endsequence
  // ======
  // properties
  property p_rsp; i_cmd_valid ##1 !i_cmd_valid |-> o_rsp_valid ##1 !o_rsp_valid; endproperty
  a_rsp: assert property (p_rsp)
    else $error("response pulse wrong");
  property p_hw; s_wr_rd(1'b1, 4'h2) |=>
    o_rsp_word[8:5] == $past(i_cmd_word[8:5], 2); endproperty
  a_hw: assert property (p_hw)
    else $error("clock setup readback wrong");
  property p_ch; s_wr_rd(1'b1, 4'h8) |=>
    o_rsp_word[6:0] == $past(i_cmd_word[6:0], 2); endproperty
  a_ch: assert property (p_ch)
    else $error("channel setup readback wrong");
  property p_pc; s_wr_rd(1'b0, 4'h7) |=>
    o_rsp_word[3:0] == $past(i_cmd_word[3:0], 2); endproperty
  a_pc: assert property (p_pc)
    else $error("pwm setup readback wrong");
  property p_dc; s_wr_rd(1'b0, 4'h8) |=>
    o_rsp_word[8:0] == $past(i_cmd_word[8:0], 2); endproperty
  a_dc: assert property (p_dc)
    else $error("duty readback wrong");
  property p_off; (i_channel_switch == '0) [*3] |-> o_channel_on == '0; endproperty
  a_off: assert property (p_off)
    else $error("channel on without request");
  property p_sync; |o_sense_sync |=> (o_sense_sync & $past(o_sense_sync)) == '0; endproperty
  a_sync: assert property (p_sync)
    else $error("sense sync longer than a cycle");
  property p_clr; $fell(o_diag_word[11]) |->
    $past(i_diag_read) || $past(i_diag_read, 2); endproperty
  a_clr: assert property (p_clr)
    else $error("loss flag cleared without readout");
endmodule : mpwm_sva

// file: mpwm_top.sv
// pwm generator configuration, clocking and channel timing
//
// Contract
// [RULE_01] hardware_config bit 5 picks the external clock pin at 0 and the internal oscillator at 1.
// [RULE_02] the trim field in bits 8:6 moves the internal oscillator by one step per code, 100 untrimmed.
// [RULE_03] the host switches clock source only while automatic pwm is disabled.
// [RULE_04] diagnosis bit 11 reads one while the external clock is below the monitoring threshold.
// [RULE_05] the channel prescaler 00 is normal switching, 01/10/11 divide the pwm clock by 256/512/1024.
// [RULE_06] channel bits 3:2 delay the sense sync signal by 0, 8, 16 or 24 pwm clock periods.
// [RULE_07] channel bits 6:4 shift the channel by the code times 32 pwm clock periods.
// [RULE_08] pwm_config bit 0 enables automatic pwm generation, zero stops it.
// [RULE_09] pwm_config bits 2:1 delay all timing of this device by 0, 8, 16 or 24 pwm clock periods.
// [RULE_10] pwm_config bit 3 at zero applies channel 0's duty to all channels, at one each its own.
// [RULE_11] duty 0 is off, 1 to 255 is value/256 on, bit 8 set is fully on.
// [RULE_12] each pwm period spans 256 counts of the prescaled clock.
// [RULE_13] the clock loss bit clears after each diagnosis readout, only when it was set.
// [RULE_14] generation starts at the next pwm clock edge after the enable.
// [RULE_15] a channel is on while its shifted period position is below its duty value.
// [RULE_16] duty, prescaler and phase changes take effect at the next period start; the code applies a prescaler change to or from 00 at once.
`timescale 1ns/1ps
module mpwm_top
  import mpwm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_word,
  input wire logic i_diag_read,
  input wire logic i_standby,
  input wire logic i_pwm_clk_pin,
  input wire logic [NUM_CH-1:0] i_channel_switch,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_word,
  output logic [15:0] o_diag_word,
  output logic [NUM_CH-1:0] o_channel_on,
  output logic [NUM_CH-1:0] o_sense_sync
);
  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] period_mask(input logic [1:0] presc);
    case (presc)
      PRESC_DIV1: period_mask = MASK_DIV1;
      PRESC_DIV2: period_mask = MASK_DIV2;
      default: period_mask = MASK_DIV4;
    endcase
  endfunction : period_mask

  function automatic logic [7:0] period_count(input logic [1:0] presc, input logic [CNT_W-1:0] pos);
    case (presc)
      PRESC_DIV1: period_count = pos[7:0];
      PRESC_DIV2: period_count = pos[8:1];
      default: period_count = pos[9:2];
    endcase
  endfunction : period_count

  // ==========================================================
  // registers
  mpwm_hw_t hw_ff, nxt_hw;
  mpwm_pcfg_t pcfg_ff, nxt_pcfg;
  mpwm_chcfg_t chcfg_ff [NUM_CH];
  mpwm_chcfg_t nxt_chcfg [NUM_CH];
  logic [DUTY_W-1:0] duty_ff [NUM_CH];
  logic [DUTY_W-1:0] nxt_duty [NUM_CH];
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] rsp_word_ff, nxt_rsp_word;
  logic loss_flag_ff, nxt_loss_flag;
  logic [15:0] diag_ff, nxt_diag;
  logic loss_now;
  logic wr;
  logic bank;
  logic [3:0] addr;
  logic [2:0] ch_sel;
  logic [DATA_W-1:0] wdata;

  always_comb begin
    wr = i_cmd_valid & i_cmd_word[FR_WRITE_BIT];
    bank = i_cmd_word[FR_BANK_BIT];
    addr = i_cmd_word[FR_ADDR_HI:FR_ADDR_LO];
    ch_sel = i_cmd_word[FR_CH_HI:FR_CH_LO];
    wdata = i_cmd_word[DATA_W-1:0];
    nxt_hw = hw_ff;
    nxt_pcfg = pcfg_ff;
    nxt_chcfg = chcfg_ff;
    nxt_duty = duty_ff;
    nxt_rsp_valid = i_cmd_valid;
    nxt_rsp_word = 16'h0000;
    if (bank && addr == ADDR_HW_CONFIG) begin
      if (wr) begin
        // [RULE_01] [RULE_02] clock source and trim
        nxt_hw.trim = wdata[HW_TRIM_HI:HW_TRIM_LO];
        nxt_hw.clk_int = wdata[HW_CLK_BIT];
        nxt_hw.load_type_sel_3 = wdata[HW_LOAD_TYPE_SEL_3_BIT];
        nxt_hw.load_type_sel_2 = wdata[HW_LOAD_TYPE_SEL_2_BIT];
      end
      nxt_rsp_word[HW_TRIM_HI:HW_TRIM_LO] = hw_ff.trim;
      nxt_rsp_word[HW_CLK_BIT] = hw_ff.clk_int;
      nxt_rsp_word[HW_LOAD_TYPE_SEL_3_BIT] = hw_ff.load_type_sel_3;
      nxt_rsp_word[HW_LOAD_TYPE_SEL_2_BIT] = hw_ff.load_type_sel_2;
      nxt_rsp_word[HW_STBY_BIT] = i_standby;
    end else if (bank && i_cmd_word[FR_CH_SEL_BIT] && ch_sel < 3'(NUM_CH)) begin
      if (wr) begin
        nxt_chcfg[ch_sel] = wdata[CH_PHASE_HI:CH_PRESC_LO];
      end
      nxt_rsp_word[CH_PHASE_HI:CH_PRESC_LO] = chcfg_ff[ch_sel];
    end else if (!bank && addr == ADDR_PWM_CONFIG) begin
      if (wr) begin
        // [RULE_08] [RULE_09] [RULE_10] global pwm setup
        nxt_pcfg = wdata[PC_DCS_BIT:PC_EN_BIT];
      end
      nxt_rsp_word[PC_DCS_BIT:PC_EN_BIT] = pcfg_ff;
    end else if (!bank && i_cmd_word[FR_CH_SEL_BIT] && ch_sel < 3'(NUM_CH)) begin
      if (wr) begin
        nxt_duty[ch_sel] = wdata[DUTY_W-1:0];
      end
      nxt_rsp_word[DUTY_W-1:0] = duty_ff[ch_sel];
    end
    // [RULE_04] [RULE_13] sticky loss bit, a new loss beats the readout clear
    nxt_loss_flag = loss_flag_ff;
    if (i_diag_read && loss_flag_ff) begin
      nxt_loss_flag = 1'b0;
    end
    if (loss_now) begin
      nxt_loss_flag = 1'b1;
    end
    nxt_diag = 16'h0000;
    nxt_diag[DIAG_LOSS_BIT] = nxt_loss_flag;
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      hw_ff <= HW_RESET;
      pcfg_ff <= '0;
      chcfg_ff <= '{default: '0};
      duty_ff <= '{default: '0};
      rsp_valid_ff <= 1'b0;
      rsp_word_ff <= 16'h0000;
      loss_flag_ff <= 1'b0;
      diag_ff <= 16'h0000;
    end else begin
      hw_ff <= nxt_hw;
      pcfg_ff <= nxt_pcfg;
      chcfg_ff <= nxt_chcfg;
      duty_ff <= nxt_duty;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_word_ff <= nxt_rsp_word;
      loss_flag_ff <= nxt_loss_flag;
      diag_ff <= nxt_diag;
    end
  end

  // ==========================================================
  // pwm clock: external pin or trimmed oscillator
  logic [2:0] pin_sync_ff, nxt_pin_sync;
  logic [11:0] gap_ff, nxt_gap;
  logic [9:0] osc_ff, nxt_osc;
  logic [9:0] osc_top;
  logic ext_edge;
  logic tick;

  always_comb begin
    // stage 0 feeds stage 1 only; edges are seen between stages 1 and 2
    nxt_pin_sync = {pin_sync_ff[1:0], i_pwm_clk_pin};
    ext_edge = pin_sync_ff[1] & ~pin_sync_ff[2];
    // [RULE_02] code 100 gives the nominal divider, lower codes lengthen the period
    osc_top = 10'(INT_DIV_CYC + int'(TRIM_NEUTRAL) * TRIM_STEP_CYC)
            - 10'(hw_ff.trim) * 10'(TRIM_STEP_CYC);
    nxt_osc = (osc_ff >= osc_top - 10'h001) ? 10'h000 : osc_ff + 10'h001;
    // [RULE_01] time base select
    tick = hw_ff.clk_int ? (osc_ff == 10'h000) : ext_edge;
    // [RULE_04] gap watchdog; held off in stand-by where the bit is not valid
    nxt_gap = (ext_edge || i_standby) ? 12'h000 : gap_ff;
    loss_now = 1'b0;
    if (!ext_edge && !i_standby) begin
      if (gap_ff >= 12'(LOSS_CYC)) begin
        loss_now = 1'b1;
      end else begin
        nxt_gap = gap_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pin_sync_ff <= 3'h0;
      gap_ff <= 12'h000;
      osc_ff <= 10'h000;
    end else begin
      pin_sync_ff <= nxt_pin_sync;
      gap_ff <= nxt_gap;
      osc_ff <= nxt_osc;
    end
  end

  // ==========================================================
  // common period counter
  logic run_ff, nxt_run;
  logic step_ff, nxt_step;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_run = run_ff;
    nxt_cnt = cnt_ff;
    nxt_step = 1'b0;
    if (!pcfg_ff.en) begin
      // [RULE_08] disabled: counter parked
      nxt_run = 1'b0;
      nxt_cnt = '0;
    end else if (tick) begin
      nxt_step = 1'b1;
      // [RULE_14] first pwm clock edge after enable starts at count zero
      if (!run_ff) begin
        nxt_run = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      run_ff <= 1'b0;
      step_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      run_ff <= nxt_run;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================================
  // channels
  logic [NUM_CH-1:0] on_ff;
  logic [NUM_CH-1:0] sync_ff;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      mpwm_shadow_t shd_ff, nxt_shd;
      logic act_ff, nxt_act;
      logic nxt_on;
      logic nxt_sync;
      logic [CNT_W-1:0] pos;
      logic [CNT_W-1:0] offset;
      logic [DUTY_W-1:0] duty_src;

      always_comb begin
        // [RULE_10] duty source
        duty_src = pcfg_ff.duty_source_select ? duty_ff[g] : duty_ff[0];
        // [RULE_07] [RULE_09] device and channel shift
        pos = cnt_ff - (CNT_W'(pcfg_ff.dev_phase) << DEV_SHIFT)
            - (CNT_W'(shd_ff.cfg.phase) << PHASE_SHIFT);
        // [RULE_05] [RULE_12] 256 prescaled counts per period
        offset = pos & period_mask(shd_ff.cfg.presc);
        nxt_shd = shd_ff;
        nxt_act = act_ff;
        nxt_sync = 1'b0;
        if (!run_ff) begin
          nxt_act = 1'b0;
          nxt_shd = '{duty: duty_src, cfg: chcfg_ff[g]};
        end else if (step_ff && offset == '0) begin
          // [RULE_16] settings latched at period start while running, and followed freely while stopped
          nxt_act = 1'b1;
          nxt_shd = '{duty: duty_src, cfg: chcfg_ff[g]};
        end
        // [RULE_06] sense sync delayed from period start
        // next activity, so a zero delay also pulses in the first period
        if (step_ff && nxt_act && offset == (CNT_W'(shd_ff.cfg.sydel) << SYNC_SHIFT)) begin
          nxt_sync = 1'b1;
        end
        // [RULE_15] [RULE_11] compare position against duty
        nxt_on = nxt_act & i_channel_switch[g]
               & (nxt_shd.duty[DUTY_W-1] | (period_count(shd_ff.cfg.presc, pos) < nxt_shd.duty[7:0]));
        // [RULE_05] normal mode follows the switch directly
        if (chcfg_ff[g].presc == PRESC_NORMAL) begin
          nxt_on = i_channel_switch[g];
          nxt_sync = 1'b0;
        end
      end

      always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
          shd_ff <= '0;
          act_ff <= 1'b0;
          on_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          shd_ff <= nxt_shd;
          act_ff <= nxt_act;
          on_ff[g] <= nxt_on;
          sync_ff[g] <= nxt_sync;
        end
      end
    end
  endgenerate

  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp_word = rsp_word_ff;
  assign o_diag_word = diag_ff;
  assign o_channel_on = on_ff;
  assign o_sense_sync = sync_ff;
endmodule : mpwm_top

// file: mpwm_top_tb.sv
// self-checking testbench of the pwm generator
`timescale 1ns/1ps
module mpwm_top_tb import mpwm_pkg::*;;
  localparam int HALF = 80;
  localparam int PER = 256 * 2 * HALF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby = 1'b0;
  logic [NUM_CH-1:0] sw = '0;
  logic cmd_valid, diag_read, pin, rsp_valid;
  logic [15:0] cmd_word, rsp_word, diag_word, r;
  logic [NUM_CH-1:0] ch_on, sync;
  logic [9:0] v;
  int err_count = 0;
  int num_checks = 0;
  int on0, on1, k, t_on0, t_on1, t_sy0, n_sy;
  logic p0, p1;
  initial forever #12.5 clk = ~clk;
  mpwm_host #(.HALF_CYC(HALF)) mpwm_host_i (.i_clock(clk), .i_rsp_word(rsp_word),
    .o_cmd_valid(cmd_valid), .o_cmd_word(cmd_word), .o_diag_read(diag_read),
    .o_pwm_clk_pin(pin));
  mpwm_top mpwm_top_i (.i_clock(clk), .i_resetn(rst_n), .i_cmd_valid(cmd_valid),
    .i_cmd_word(cmd_word), .i_diag_read(diag_read), .i_standby(standby),
    .i_pwm_clk_pin(pin), .i_channel_switch(sw), .o_rsp_valid(rsp_valid),
    .o_rsp_word(rsp_word), .o_diag_word(diag_word), .o_channel_on(ch_on),
    .o_sense_sync(sync));
  // ======
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rw(input logic w, input logic b, input logic [3:0] a, input logic [9:0] d);
    mpwm_host_i.acc({w, b, a, d}, {1'b0, b, a, 10'h000}, r);
  endtask : rw
  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // ======
  // tests
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rw(1'b0, 1'b1, 4'h2, 10'h000);
    chk({6'h00, r[9:0]}, 16'h0100, "clock setup reset");
    rw(1'b0, 1'b0, 4'h7, 10'h000);
    chk(r, 16'h0000, "pwm setup reset");
    $display("test reset_values done");
    for (k = 0; k < 8; k++) begin
      rw(1'b1, 1'b1, 4'h2, {1'b0, k[2:0], k[0], 5'h00});
      chk({6'h00, r[9:0]}, {7'h00, k[2:0], k[0], 5'h00}, "trim and source");
    end
    rw(1'b1, 1'b1, 4'h2, 10'h100);
    for (k = 0; k < 8; k++) begin
      v = (k == 0) ? 10'h005 : (k == 1) ? 10'h011 : {3'h0, k[2:0], k[1:0], k[1:0]};
      rw(1'b1, 1'b1, {1'b1, k[2:0]}, v);
      chk({6'h00, r[9:0]}, (k < 6) ? {6'h00, v} : 16'h0000, "channel setup");
      v = (k == 0) ? 10'h080 : 10'h100;
      rw(1'b1, 1'b0, {1'b1, k[2:0]}, v);
      chk({6'h00, r[9:0]}, (k < 6) ? {6'h00, v} : 16'h0000, "duty");
    end
    rw(1'b1, 1'b0, 4'h2, 10'h3ff);
    chk(r, 16'h0000, "unmapped");
    $display("test registers done");
    mpwm_host_i.clk_run = 1'b0;
    standby = 1'b1;
    repeat (LOSS_CYC + 20) @(negedge clk);
    chk(diag_word, 16'h0000, "loss in standby");
    standby = 1'b0;
    repeat (LOSS_CYC + 20) @(negedge clk);
    chk(diag_word, 16'h0800, "loss flag");
    mpwm_host_i.diag_rd();
    repeat (3) @(negedge clk);
    chk(diag_word, 16'h0800, "loss kept");
    mpwm_host_i.clk_run = 1'b1;
    repeat (5 * HALF) @(negedge clk);
    mpwm_host_i.diag_rd();
    repeat (3) @(negedge clk);
    chk(diag_word, 16'h0000, "loss cleared");
    $display("test clock_loss done");
    // switch on 0, 1 and normal-mode channel 4
    sw = 6'h13;
    rw(1'b1, 1'b0, 4'h7, 10'h003);
    chk(r, 16'h0003, "pwm setup");
    k = 0;
    while (ch_on[1] !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk({15'h0000, ch_on[1]}, 16'h0001, "shifted start");
    on0 = 0;
    on1 = 0;
    t_on0 = 0;
    t_on1 = 0;
    t_sy0 = 0;
    n_sy = 0;
    p0 = ch_on[0];
    p1 = ch_on[1];
    // window of exactly one period: rises and sync pulse are seen once each
    for (k = 0; k < PER; k++) begin
      @(negedge clk);
      on0 += int'(ch_on[0] === 1'b1);
      on1 += int'(ch_on[1] === 1'b1);
      if (ch_on[0] === 1'b1 && p0 !== 1'b1) t_on0 = k;
      if (ch_on[1] === 1'b1 && p1 !== 1'b1) t_on1 = k;
      if (sync[0] === 1'b1) begin
        t_sy0 = k;
        n_sy++;
      end
      p0 = ch_on[0];
      p1 = ch_on[1];
    end
    chk(16'(on0), 16'(128 * 2 * HALF), "on time ch0");
    chk(16'(on1), 16'(128 * 2 * HALF), "shared duty ch1");
    chk(16'(n_sy), 16'h0001, "sync pulses ch0");
    chk(16'((t_sy0 - t_on0 + PER) % PER), 16'(8 * 2 * HALF), "sync delay ch0");
    chk(16'((t_on1 - t_on0 + PER) % PER), 16'(32 * 2 * HALF), "phase ch1");
    rw(1'b1, 1'b0, 4'h7, 10'h000);
    repeat (4) @(negedge clk);
    chk({13'h0000, ch_on[4], ch_on[1:0]}, 16'h0004, "generation off");
    $display("test pwm done");
    close_out();
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule : mpwm_top_tb
bind mpwm_top mpwm_sva mpwm_sva_i (.i_clock, .i_resetn, .i_cmd_valid, .i_cmd_word,
  .i_diag_read, .i_channel_switch, .o_rsp_valid, .o_rsp_word, .o_diag_word,
  .o_channel_on, .o_sense_sync);
